// ==== logic/acs_pkg.sv ====
// Shared constants and types of the converter calibration sequencer
package acs_pkg;

  // Worst-case sequence lengths in master clock cycles
  localparam int unsigned SELF_CAL_CYCLES    = 3145655;
  localparam int unsigned SYS_OFFSET_CYCLES  = 1052599;
  localparam int unsigned SYS_GAIN_CYCLES    = 1068813;
  localparam int unsigned ONE_STEP_CYCLES    = 2117389;
  // Filter settling after a calibration, in master clock cycles
  localparam int unsigned SETTLE_CYCLES      = 507904;

  localparam int                 CNT_W        = 22;
  localparam int                 HI_W         = 3;
  localparam logic [HI_W-1:0]    CAL_MIN_HIGH = 3'h4;

  // Register map, byte addresses on the 32-bit bus
  localparam int                 ADDR_W       = 12;
  localparam logic [ADDR_W-1:0]  REG_CTRL     = 12'h000;
  localparam logic [ADDR_W-1:0]  REG_STATUS   = 12'h004;
  localparam logic [ADDR_W-1:0]  REG_ELAPSED  = 12'h008;
  localparam int                 CTRL_BIPOLAR_BIT = 0;
  localparam logic               CTRL_BIPOLAR_RESET = 1'h0;

  // Mode code is {cal_select_a, cal_select_b}
  typedef enum logic [1:0] {
    MODE_SELF    = 2'h0,
    MODE_GAIN    = 2'h1,
    MODE_ONESTEP = 2'h2,
    MODE_OFFSET  = 2'h3
  } acs_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ZERO   = 4'h2,
    ST_FULL   = 4'h4,
    ST_SETTLE = 4'h8
  } acs_state_t;

  // Input the modulator is connected to during a step
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_GND  = 2'h1,
    SRC_REF  = 2'h2,
    SRC_AIN  = 2'h3
  } acs_src_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } acs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } acs_apb_rsp_t;

  typedef struct packed {
    logic [CNT_W-1:0] elapsed;
    acs_mode_t        mode;
    logic             stepFull;
    logic             stepZero;
    logic             calibrated;
    logic             hold;
    logic             busy;
  } acs_status_t;

endpackage : acs_pkg

// ==== logic/acs_apb_regs.sv ====
// APB register slave of the calibration sequencer
`timescale 1ns/10ps
module acs_apb_regs (
  input  logic                 sys_clk,
  input  logic                 rst,
  input  acs_pkg::acs_apb_req_t apbReq,
  input  acs_pkg::acs_status_t  status,
  output acs_pkg::acs_apb_rsp_t apbRsp,
  output logic                 rangeBipolar
);

  logic        access;
  logic        hit;
  logic [31:0] readData;

  assign access = apbReq.psel & apbReq.penable;

  always_comb begin
    hit      = 1'b1;
    readData = 32'h0;
    case (apbReq.paddr)
      acs_pkg::REG_CTRL:    readData = {31'h0, rangeBipolar};
      acs_pkg::REG_STATUS:  readData = {25'h0, status.mode, status.stepFull, status.stepZero,
                                        status.calibrated, status.hold, status.busy};
      acs_pkg::REG_ELAPSED: readData = {{(32 - acs_pkg::CNT_W){1'b0}}, status.elapsed};
      default:              hit = 1'b0;
    endcase
  end

  // One wait state so that every response signal leaves a flip-flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      apbRsp <= '0;
    end else if (access && !apbRsp.pready) begin
      apbRsp.pready  <= 1'b1;
      apbRsp.prdata  <= apbReq.pwrite ? 32'h0 : readData;
      apbRsp.pslverr <= ~hit;
    end else begin
      apbRsp <= '0;
    end
  end

  // Write lands only at the completing edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rangeBipolar <= acs_pkg::CTRL_BIPOLAR_RESET;
    end else if (access && apbRsp.pready && apbReq.pwrite && apbReq.paddr == acs_pkg::REG_CTRL) begin
      rangeBipolar <= apbReq.pwdata[acs_pkg::CTRL_BIPOLAR_BIT];
    end
  end

endmodule : acs_apb_regs

// ==== logic/adc_calibration_sequencer.sv ====
// Calibration sequencer: strobe capture, step timing and data-ready hold
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
module adc_calibration_sequencer #(
  parameter int unsigned SELF_CYCLES    = acs_pkg::SELF_CAL_CYCLES,
  parameter int unsigned OFFSET_CYCLES  = acs_pkg::SYS_OFFSET_CYCLES,
  parameter int unsigned GAIN_CYCLES    = acs_pkg::SYS_GAIN_CYCLES,
  parameter int unsigned ONESTEP_CYCLES = acs_pkg::ONE_STEP_CYCLES,
  parameter int unsigned SETTLE         = acs_pkg::SETTLE_CYCLES
) (
  input  logic                  sys_clk,
  input  logic                  rst,
  input  acs_pkg::acs_apb_req_t apbReq,
  output acs_pkg::acs_apb_rsp_t apbRsp,
  input  logic                  calStrobe,
  input  logic                  cal_select_a,
  input  logic                  cal_select_b,
  input  logic                  convReadyN,
  output logic                  word_ready_n,
  output logic                  calBusy,
  output logic                  calZeroStep,
  output logic                  calFullStep,
  output logic                  calMidscale,
  output acs_pkg::acs_src_t     calSource
);

  localparam int CW = acs_pkg::CNT_W;

  logic [2:0]                     pinMeta;
  logic [2:0]                     pinSync;
  logic                           calSync;
  logic                           calLast;
  logic [acs_pkg::HI_W-1:0]       hiCnt;
  logic                           startCal;
  logic                           rangeBipolar;
  acs_pkg::acs_state_t            state;
  acs_pkg::acs_state_t            next_state;
  acs_pkg::acs_mode_t             curMode;
  acs_pkg::acs_mode_t             next_mode;
  logic                           curBipolar;
  logic                           next_bipolar;
  logic [CW-1:0]                  elapsed;
  logic [CW-1:0]                  next_elapsed;
  logic [CW-1:0]                  zeroEnd;
  logic [CW-1:0]                  fullEnd;
  logic [CW-1:0]                  seqEnd;
  logic                           hold;
  logic                           next_hold;
  logic                           calibrated;
  acs_pkg::acs_status_t           status;

  // Pins come from the outside controller
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
    end else begin
      pinMeta <= {calStrobe, cal_select_a, cal_select_b};
      pinSync <= pinMeta;
    end
  end

  assign calSync = pinSync[2];

  // Count strobe high time, saturating at the minimum
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      calLast <= 1'b0;
      hiCnt   <= '0;
    end else begin
      calLast <= calSync;
      if (!calSync) begin
        hiCnt <= '0;
      end else if (hiCnt != acs_pkg::CAL_MIN_HIGH) begin
        hiCnt <= hiCnt + 1'b1;
      end
    end
  end

  // Short strobes and strobes during a sequence are ignored
  assign startCal = calLast && !calSync && hiCnt >= acs_pkg::CAL_MIN_HIGH
                    && state == acs_pkg::ST_IDLE;

  // Step boundaries, counted in cycles from the start of the sequence
  always_comb begin
    zeroEnd = CW'(SELF_CYCLES - SETTLE) >> 1;
    fullEnd = CW'(SELF_CYCLES - SETTLE);
    seqEnd  = CW'(SELF_CYCLES);
    case (curMode)
      acs_pkg::MODE_OFFSET: begin
        zeroEnd = CW'(OFFSET_CYCLES);
        fullEnd = CW'(OFFSET_CYCLES);
        seqEnd  = CW'(OFFSET_CYCLES + SETTLE);
      end
      acs_pkg::MODE_GAIN: begin
        zeroEnd = '0;
        fullEnd = CW'(GAIN_CYCLES);
        seqEnd  = CW'(GAIN_CYCLES + SETTLE);
      end
      acs_pkg::MODE_ONESTEP: begin
        zeroEnd = CW'(ONESTEP_CYCLES) >> 1;
        fullEnd = CW'(ONESTEP_CYCLES);
        seqEnd  = CW'(ONESTEP_CYCLES + SETTLE);
      end
      default: begin
        zeroEnd = CW'(SELF_CYCLES - SETTLE) >> 1;
        fullEnd = CW'(SELF_CYCLES - SETTLE);
        seqEnd  = CW'(SELF_CYCLES);
      end
    endcase
  end

  always_comb begin
    next_state   = state;
    next_elapsed = elapsed + 1'b1;
    case (state)
      acs_pkg::ST_IDLE: begin
        next_elapsed = elapsed;
        if (startCal) begin
          next_elapsed = '0;
          next_state   = (acs_pkg::acs_mode_t'(pinSync[1:0]) == acs_pkg::MODE_GAIN)
                         ? acs_pkg::ST_FULL : acs_pkg::ST_ZERO;
        end
      end
      acs_pkg::ST_ZERO: begin
        if (next_elapsed == zeroEnd) begin
          next_state = (fullEnd != zeroEnd) ? acs_pkg::ST_FULL : acs_pkg::ST_SETTLE;
        end
      end
      acs_pkg::ST_FULL: begin
        if (next_elapsed == fullEnd) begin
          next_state = acs_pkg::ST_SETTLE;
        end
      end
      acs_pkg::ST_SETTLE: begin
        if (next_elapsed == seqEnd) begin
          next_state = acs_pkg::ST_IDLE;
        end
      end
      default: next_state = acs_pkg::ST_IDLE;
    endcase
  end

  // Selects and range are frozen at the strobe fall
  assign next_mode    = startCal ? acs_pkg::acs_mode_t'(pinSync[1:0]) : curMode;
  assign next_bipolar = startCal ? rangeBipolar : curBipolar;

  // Self-calibration keeps data-ready high through settling; system modes do not
  assign next_hold = (next_state == acs_pkg::ST_ZERO) || (next_state == acs_pkg::ST_FULL)
                     || (next_state == acs_pkg::ST_SETTLE && next_mode == acs_pkg::MODE_SELF);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state      <= acs_pkg::ST_IDLE;
      elapsed    <= '0;
      curMode    <= acs_pkg::MODE_SELF;
      curBipolar <= 1'b0;
      hold       <= 1'b0;
    end else begin
      state      <= next_state;
      elapsed    <= next_elapsed;
      curMode    <= next_mode;
      curBipolar <= next_bipolar;
      hold       <= next_hold;
    end
  end

  // Calibrated flag; conversions before the first one are not trustworthy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      calibrated <= 1'b0;
    end else if (state == acs_pkg::ST_SETTLE && next_state == acs_pkg::ST_IDLE) begin
      calibrated <= 1'b1;
    end
  end

  // Data-ready: forced high while held, low for the release, then the filter's flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      word_ready_n <= 1'b1;
    end else if (next_hold) begin
      word_ready_n <= 1'b1;
    end else if (hold) begin
      word_ready_n <= 1'b0;
    end else begin
      word_ready_n <= convReadyN;
    end
  end

  // Step outputs steer the analog front end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      calBusy     <= 1'b0;
      calZeroStep <= 1'b0;
      calFullStep <= 1'b0;
      calMidscale <= 1'b0;
      calSource   <= acs_pkg::SRC_NONE;
    end else begin
      calBusy     <= next_state != acs_pkg::ST_IDLE;
      calZeroStep <= next_state == acs_pkg::ST_ZERO;
      calFullStep <= next_state == acs_pkg::ST_FULL;
      calMidscale <= next_state == acs_pkg::ST_ZERO && next_bipolar;
      if (next_state == acs_pkg::ST_ZERO) begin
        calSource <= (next_mode == acs_pkg::MODE_SELF) ? acs_pkg::SRC_GND : acs_pkg::SRC_AIN;
      end else if (next_state == acs_pkg::ST_FULL) begin
        calSource <= (next_mode == acs_pkg::MODE_GAIN) ? acs_pkg::SRC_AIN : acs_pkg::SRC_REF;
      end else begin
        calSource <= acs_pkg::SRC_NONE;
      end
    end
  end

  assign status = '{elapsed:    elapsed,
                    mode:       curMode,
                    stepFull:   calFullStep,
                    stepZero:   calZeroStep,
                    calibrated: calibrated,
                    hold:       hold,
                    busy:       calBusy};

  acs_apb_regs u_regs (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .apbReq       (apbReq),
    .status       (status),
    .apbRsp       (apbRsp),
    .rangeBipolar (rangeBipolar)
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_short_strobe: assert property (($fell(calSync) && hiCnt < acs_pkg::CAL_MIN_HIGH && state == acs_pkg::ST_IDLE)
                                   |=> state == acs_pkg::ST_IDLE)
    else $error("short strobe started a calibration");
  a_strobe_start: assert property (startCal |=> calBusy && hold && word_ready_n)
    else $error("valid strobe did not start a calibration");
  a_self_time: assert property ((calBusy && curMode == acs_pkg::MODE_SELF) |-> elapsed < CW'(SELF_CYCLES))
    else $error("self calibration overran its limit");
  a_self_source: assert property ((calBusy && curMode == acs_pkg::MODE_SELF)
                                  |-> (calZeroStep ? calSource == acs_pkg::SRC_GND
                                       : (!calFullStep || calSource == acs_pkg::SRC_REF)))
    else $error("self calibration used a wrong source");
  a_bipolar_mid: assert property (calZeroStep |-> calMidscale == curBipolar)
    else $error("midscale flag does not follow the latched range");
  a_offset_time: assert property ((hold && curMode == acs_pkg::MODE_OFFSET)
                                  |-> elapsed < CW'(OFFSET_CYCLES) && calSource == acs_pkg::SRC_AIN)
    else $error("system offset step overran or used a wrong source");
  a_gain_time: assert property ((hold && curMode == acs_pkg::MODE_GAIN)
                                |-> elapsed < CW'(GAIN_CYCLES) && calFullStep && calSource == acs_pkg::SRC_AIN)
    else $error("system gain step overran or used a wrong source");
  a_onestep_time: assert property ((hold && curMode == acs_pkg::MODE_ONESTEP) |-> elapsed < CW'(ONESTEP_CYCLES)
                                   && (calZeroStep ? calSource == acs_pkg::SRC_AIN : calSource == acs_pkg::SRC_REF))
    else $error("one-step offset overran or used a wrong source");
  a_ready_held: assert property ((hold && calBusy) |-> word_ready_n)
    else $error("data-ready fell during calibration");
  a_self_release: assert property (($fell(hold) && curMode == acs_pkg::MODE_SELF)
                                   |-> state == acs_pkg::ST_IDLE && !word_ready_n)
    else $error("self calibration released data-ready before settling");
  a_sys_release: assert property (($fell(hold) && curMode != acs_pkg::MODE_SELF)
                                  |-> state == acs_pkg::ST_SETTLE && !word_ready_n)
    else $error("system calibration did not release data-ready at settling");
  a_mode_frozen: assert property ((calBusy && $past(calBusy)) |-> $stable(curMode) && $stable(curBipolar))
    else $error("latched selects changed during a sequence");

  // Idle pass-through and step bookkeeping
  a_idle_quiet: assert property (!calBusy |-> !calZeroStep && !calFullStep && !calMidscale
                                 && calSource == acs_pkg::SRC_NONE)
    else $error("step outputs active while idle");
  a_idle_follow: assert property ((!hold && !$past(hold) && !$past(rst))
                                  |-> word_ready_n == $past(convReadyN))
    else $error("data-ready does not follow the conversion side");
  a_seq_bound: assert property (calBusy |-> elapsed < seqEnd)
    else $error("sequence ran past its end");
  a_mid_zero: assert property (calMidscale |-> calZeroStep)
    else $error("midscale flag outside the zero step");
  a_gain_direct: assert property ((startCal && acs_pkg::acs_mode_t'(pinSync[1:0]) == acs_pkg::MODE_GAIN)
                                  |=> calFullStep && !calZeroStep)
    else $error("gain step did not start at full scale");
  a_calib_set: assert property ($fell(calBusy) |-> calibrated)
    else $error("calibrated flag not set at sequence end");

  c_self_done: cover property ($fell(hold) && curMode == acs_pkg::MODE_SELF);
  c_offset_done: cover property ($fell(hold) && curMode == acs_pkg::MODE_OFFSET);
  c_gain_done: cover property ($fell(hold) && curMode == acs_pkg::MODE_GAIN);
  c_onestep_done: cover property ($fell(hold) && curMode == acs_pkg::MODE_ONESTEP);
  c_short_strobe: cover property ($fell(calSync) && hiCnt < acs_pkg::CAL_MIN_HIGH && state == acs_pkg::ST_IDLE);

endmodule : adc_calibration_sequencer

// ==== tb/acs_ctrl_model.sv ====
// Behavioural system controller that drives the calibration pins
`timescale 1ns/10ps
module acs_ctrl_model (
  input  wire logic sys_clk,
  output logic      calStrobe,
  output logic      cal_select_a,
  output logic      cal_select_b,
  output logic      convReadyN
);
  initial begin
    calStrobe    = 1'b0;
    cal_select_a = 1'b0;
    cal_select_b = 1'b0;
    convReadyN   = 1'b0;
  end

  // Conversion side keeps changing, so a stuck hold shows up
  always @(posedge sys_clk) begin
    convReadyN <= ~convReadyN;
  end

  task automatic pulse(input logic [1:0] mode, input int highLen);
    @(posedge sys_clk);
    {cal_select_a, cal_select_b} <= mode;
    calStrobe <= 1'b1;
    repeat (highLen) @(posedge sys_clk);
    calStrobe <= 1'b0;
    @(posedge sys_clk);
    // Selects move after the fall; the latched mode must not follow
    {cal_select_a, cal_select_b} <= ~mode;
  endtask : pulse
endmodule : acs_ctrl_model

// ==== tb/adc_calibration_sequencer_tb_top.sv ====
// Self-checking bench of the calibration sequencer
`timescale 1ns/10ps
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error %0t: got %0h expected %0h", $time, got, exp); end end
module adc_calibration_sequencer_tb_top;
  // Short counts keep the run brief; expectations derive from them
  localparam int unsigned SELF = 60;
  localparam int unsigned OFS  = 20;
  localparam int unsigned GAIN = 22;
  localparam int unsigned ONE  = 30;
  localparam int unsigned SET  = 8;
  logic                  sys_clk = 1'b0;
  logic                  rst     = 1'b1;
  acs_pkg::acs_apb_req_t apbReq  = '0;
  acs_pkg::acs_apb_rsp_t apbRsp;
  logic                  calStrobe;
  logic                  cal_select_a;
  logic                  cal_select_b;
  logic                  convReadyN;
  logic                  word_ready_n;
  logic                  calBusy;
  logic                  calZeroStep;
  logic                  calFullStep;
  logic                  calMidscale;
  acs_pkg::acs_src_t     calSource;
  logic [31:0]           rd;
  logic                  err;
  logic                  busySeen;
  int                    miscompares = 0;
  int                    testsRun    = 0;

  always #10 sys_clk = ~sys_clk;

  acs_ctrl_model ctl (.sys_clk(sys_clk), .calStrobe(calStrobe), .cal_select_a(cal_select_a),
    .cal_select_b(cal_select_b), .convReadyN(convReadyN));

  adc_calibration_sequencer #(.SELF_CYCLES(SELF), .OFFSET_CYCLES(OFS), .GAIN_CYCLES(GAIN),
    .ONESTEP_CYCLES(ONE), .SETTLE(SET)) dut (.sys_clk(sys_clk), .rst(rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .calStrobe(calStrobe), .cal_select_a(cal_select_a), .cal_select_b(cal_select_b),
    .convReadyN(convReadyN), .word_ready_n(word_ready_n), .calBusy(calBusy), .calZeroStep(calZeroStep),
    .calFullStep(calFullStep), .calMidscale(calMidscale), .calSource(calSource));

  task automatic print_verdict;
    if (miscompares == 0 && testsRun > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge sys_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    // Judge the answer itself, so a late but valid pready still passes
    if (apbRsp.pready !== 1'b1) begin
      miscompares++;
      print_verdict();
    end else begin
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq <= '0;
    end
  endtask : apb

  task automatic run_cal(input logic [1:0] mode, input int unsigned busyLen, input int unsigned holdLen,
                         input acs_pkg::acs_src_t zSrc, input acs_pkg::acs_src_t fSrc, input logic bip);
    int unsigned       busyCnt;
    int unsigned       holdCnt;
    int                n;
    logic              holding;
    logic              mid;
    acs_pkg::acs_src_t zSeen;
    acs_pkg::acs_src_t fSeen;
    busyCnt = 0;
    holdCnt = 0;
    n = 0;
    holding = 1'b1;
    mid = 1'b0;
    zSeen = acs_pkg::SRC_NONE;
    fSeen = acs_pkg::SRC_NONE;
    ctl.pulse(mode, 4);
    do begin
      @(negedge sys_clk);
      n++;
    end while (calBusy !== 1'b1 && n < 10);
    if (calBusy !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
    while (calBusy === 1'b1 && busyCnt < 2000) begin
      if (holding && word_ready_n === 1'b1) holdCnt++;
      else holding = 1'b0;
      if (calZeroStep === 1'b1) zSeen = calSource;
      if (calFullStep === 1'b1) fSeen = calSource;
      mid = mid | calMidscale;
      busyCnt++;
      @(negedge sys_clk);
    end
    if (calBusy === 1'b1) begin
      miscompares++;
      print_verdict();
    end
    `CHK(busyCnt, busyLen);
    `CHK(holdCnt, holdLen);
    `CHK(zSeen, zSrc);
    `CHK(fSeen, fSrc);
    `CHK(mid, bip);
  endtask : run_cal

  task automatic short_strobe;
    busySeen = 1'b0;
    ctl.pulse(acs_pkg::MODE_SELF, 3);
    repeat (12) begin
      @(negedge sys_clk);
      busySeen = busySeen | calBusy;
    end
    `CHK(busySeen, 1'b0);
  endtask : short_strobe

  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, acs_pkg::REG_CTRL, 32'h0);
    `CHK(rd, 32'h0);
    short_strobe();
    // First calibration after power-up, before results are trusted
    run_cal(acs_pkg::MODE_SELF, SELF, SELF, acs_pkg::SRC_GND, acs_pkg::SRC_REF, 1'b0);
    apb(1'b0, acs_pkg::REG_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h4);
    apb(1'b0, acs_pkg::REG_ELAPSED, 32'h0);
    `CHK(rd, 32'(SELF));
    // Offset step strictly before gain step
    run_cal(acs_pkg::MODE_OFFSET, OFS + SET, OFS, acs_pkg::SRC_AIN, acs_pkg::SRC_NONE, 1'b0);
    run_cal(acs_pkg::MODE_GAIN, GAIN + SET, GAIN, acs_pkg::SRC_NONE, acs_pkg::SRC_AIN, 1'b0);
    apb(1'b0, acs_pkg::REG_STATUS, 32'h0);
    `CHK(rd[6:5], 2'h1);
    run_cal(acs_pkg::MODE_ONESTEP, ONE + SET, ONE, acs_pkg::SRC_AIN, acs_pkg::SRC_REF, 1'b0);
    apb(1'b1, acs_pkg::REG_CTRL, 32'h1);
    apb(1'b0, acs_pkg::REG_CTRL, 32'h0);
    `CHK(rd[0], 1'b1);
    run_cal(acs_pkg::MODE_SELF, SELF, SELF, acs_pkg::SRC_GND, acs_pkg::SRC_REF, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0});
    print_verdict();
  end
endmodule : adc_calibration_sequencer_tb_top
